// ### src/hbchs_defs.vh
`ifndef HBCHS_DEFS_VH
`define HBCHS_DEFS_VH

// ****************************************************************
// Configuration dword indices (byte offset divided by four)
// ****************************************************************
`define HBCHS_DW_CMD_STS 6'h01
`define HBCHS_DW_REV_CLASS 6'h02
`define HBCHS_DW_HDR 6'h03
`define HBCHS_DW_CAP 6'h0d

// ****************************************************************
// Byte offsets as printed, and their lanes within the dword
// ****************************************************************
`define HBCHS_OFF_COMMAND 8'h04
`define HBCHS_OFF_STATUS 8'h06
`define HBCHS_OFF_REVISION 8'h08
`define HBCHS_OFF_SUB_CLASS 8'h0a
`define HBCHS_OFF_BASE_CLASS 8'h0b
`define HBCHS_OFF_LATENCY 8'h0d
`define HBCHS_OFF_HEADER 8'h0e
`define HBCHS_OFF_CAP_PTR 8'h34
`define HBCHS_LANE_CMD_HI 1
`define HBCHS_LANE_STS_HI 3

// ****************************************************************
// Status register fields and values
// ****************************************************************
`define HBCHS_STS_RESET 16'h0090
`define HBCHS_STS_SSE_BIT 14
`define HBCHS_STS_RMA_BIT 13
`define HBCHS_STS_RTA_BIT 12
`define HBCHS_STS_B2B_BIT 7
`define HBCHS_STS_CAP_BIT 4
`define HBCHS_SELECT_TIMING 2'h0

// ****************************************************************
// Command register fields and values
// ****************************************************************
`define HBCHS_CMD_FIXED 8'h06
`define HBCHS_CMD_SYSTEM_ERROR_ENABLE_BIT 8
`define HBCHS_CMD_SYSTEM_ERROR_ENABLE_RESET 1'b0

// ****************************************************************
// Read-only byte values
// ****************************************************************
`define HBCHS_SUB_CLASS 8'h00
`define HBCHS_BASE_CLASS 8'h06
`define HBCHS_LATENCY 8'h00
`define HBCHS_HEADER 8'h00
`define HBCHS_REVISION_DEFAULT 8'h01
`define HBCHS_CAP_PTR_DEFAULT 8'ha0

`endif

// ### src/hbchs_w1c_flag.v
`timescale 1ns/1ps

// ****************************************************************
// Sticky flag, set by hardware, cleared by writing one
// ****************************************************************
module hbchs_w1c_flag (
    input wire clk_sys,
    input wire rst_n,
    input wire set,
    input wire clr,
    output reg flag
);

    wire next_flag;

    // Set wins over a clear in the same cycle so no event is lost
    assign next_flag = set | (flag & ~clr);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

// ### src/hbchs_cfg_header.v
// Notes on behaviour
// - Sixteen-bit status at 06h-07h, reset 0090h, top flags clear by one
// - Parity, target-abort-sent and data-parity bits read zero, writes ignored
// - Sending a system error message sets status bit 14
// - Writing one to bit 14 clears it; writing zero leaves it
// - Master abort completion on own request sets status bit 13
// - Target abort completion on own request sets status bit 12
// - Writing one clears bits 13 or 12; only written-one bits clear
// - Select timing bits 10:9 read 00, fast decode, writes ignored
// - Bit 7 always reads one, fast back-to-back capable
// - Bit 4 reads one; capability pointer readable at 34h
// - Read-only eight-bit revision number at 08h, writes ignored
// - Base class code reads 06h, bridge device, at 0Bh
// - Latency timer byte at 0Dh reads zero, writes ignored
// - Header type byte at 0Eh reads zero, no storage
// - Messages only when error enable set; enable ORed with device one
`timescale 1ns/1ps
`include "hbchs_defs.vh"

module hbchs_cfg_header #(
    // Arbitrary neutral value, not tied to any real part
    parameter [7:0] REVISION = `HBCHS_REVISION_DEFAULT,
    parameter [7:0] CAP_POINTER = `HBCHS_CAP_PTR_DEFAULT
) (
    input wire clk_sys,
    input wire rst_n,
    input wire cfg_rd,
    input wire cfg_wr,
    input wire [5:0] cfg_dw_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    input wire hub_master_abort_cpl,
    input wire hub_target_abort_cpl,
    input wire dev0_error_event,
    input wire dev1_system_error_enable,
    output reg serr_msg_send,
    output wire hub_serr_msg_enable
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire wr_cmd_sts;
    wire wr_sts_hi;
    wire wr_cmd_hi;

    assign wr_cmd_sts = cfg_wr & (cfg_dw_addr == `HBCHS_DW_CMD_STS);
    assign wr_sts_hi = wr_cmd_sts & cfg_be[`HBCHS_LANE_STS_HI];
    assign wr_cmd_hi = wr_cmd_sts & cfg_be[`HBCHS_LANE_CMD_HI];

    // ****************************************************************
    // Command: only the system error enable is stored
    // ****************************************************************
    reg system_error_enable;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            system_error_enable <= `HBCHS_CMD_SYSTEM_ERROR_ENABLE_RESET;
        end else if (wr_cmd_hi) begin
            system_error_enable <= cfg_wdata[`HBCHS_CMD_SYSTEM_ERROR_ENABLE_BIT];
        end
    end

    // Either device's enable opens the shared message path
    assign hub_serr_msg_enable = system_error_enable |
                                 dev1_system_error_enable;

    // ****************************************************************
    // System error message and sticky status flags
    // ****************************************************************
    wire serr_fire;
    wire system_error_sent_flag;
    wire master_abort_received_flag;
    wire target_abort_received_flag;

    // Enable is sampled as it stands in the event cycle
    assign serr_fire = dev0_error_event & system_error_enable;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serr_msg_send <= 1'b0;
        end else begin
            serr_msg_send <= serr_fire;
        end
    end

    // Status lane 3 carries status bits 15:8 as write data bits 31:24
    hbchs_w1c_flag u_sse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(serr_fire),
        .clr(wr_sts_hi & cfg_wdata[16 + `HBCHS_STS_SSE_BIT]),
        .flag(system_error_sent_flag)
    );

    hbchs_w1c_flag u_rma (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(hub_master_abort_cpl),
        .clr(wr_sts_hi & cfg_wdata[16 + `HBCHS_STS_RMA_BIT]),
        .flag(master_abort_received_flag)
    );

    hbchs_w1c_flag u_rta (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(hub_target_abort_cpl),
        .clr(wr_sts_hi & cfg_wdata[16 + `HBCHS_STS_RTA_BIT]),
        .flag(target_abort_received_flag)
    );

    // ****************************************************************
    // Register images
    // ****************************************************************
    wire [15:0] bridge_status;
    wire [15:0] bridge_command;
    wire [1:0] select_timing_field;

    assign select_timing_field = `HBCHS_SELECT_TIMING;

    // Hardwired bits take no write path at all, so writes cannot touch them
    assign bridge_status = {
        1'b0,
        system_error_sent_flag,
        master_abort_received_flag,
        target_abort_received_flag,
        1'b0,
        select_timing_field,
        1'b0,
        1'b1,
        2'b00,
        1'b1,
        4'h0
    };

    assign bridge_command = {7'h00, system_error_enable, `HBCHS_CMD_FIXED};

    // ****************************************************************
    // Read path
    // ****************************************************************
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (cfg_dw_addr)
            `HBCHS_DW_CMD_STS: begin
                next_rdata = {bridge_status, bridge_command};
            end
            `HBCHS_DW_REV_CLASS: begin
                next_rdata = {`HBCHS_BASE_CLASS,
                              `HBCHS_SUB_CLASS,
                              8'h00,
                              REVISION};
            end
            `HBCHS_DW_HDR: begin
                next_rdata = {8'h00,
                              `HBCHS_HEADER,
                              `HBCHS_LATENCY,
                              8'h00};
            end
            `HBCHS_DW_CAP: begin
                next_rdata = {24'h00_0000, CAP_POINTER};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Reads have no side effects; a whole dword returns whatever the lanes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

endmodule

// ### bench/hbchs_checker.sv
`timescale 1ns/1ps
// ****
// Status header checker
// ****
module hbchs_checker #(
    parameter [7:0] REVISION = 8'h01
) (
    input logic clk_sys,
    input logic rst_n,
    input logic cfg_rd,
    input logic cfg_wr,
    input logic [5:0] cfg_dw_addr,
    input logic [3:0] cfg_be,
    input logic [31:0] cfg_wdata,
    input logic [31:0] cfg_rdata,
    input logic cfg_rvalid,
    input logic hub_master_abort_cpl,
    input logic dev0_error_event,
    input logic dev1_system_error_enable,
    input logic serr_msg_send,
    input logic hub_serr_msg_enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire rd_sts = cfg_rd && cfg_dw_addr == 6'h01;
    wire clr13 = cfg_wr && cfg_dw_addr == 6'h01 && cfg_be[3] && cfg_wdata[29];
    // Bounded waits keep both sequences checkable within a short run
    sequence ma_kept;
        hub_master_abort_cpl ##1 ((!clr13) throughout (##[0:12] rd_sts));
    endsequence
    sequence ma_cleared;
        clr13 && !hub_master_abort_cpl
            ##1 ((!hub_master_abort_cpl) throughout (##[0:12] rd_sts));
    endsequence
    a_read_answer: assert property (cfg_rvalid == $past(cfg_rd))
        else $error("read answer timing wrong");
    a_sts_fixed: assert property (
        rd_sts |=> (cfg_rdata[31:16] & 16'h8fff) == 16'h0090)
        else $error("status hardwired bits wrong");
    a_class_bytes: assert property (
        cfg_rd && cfg_dw_addr == 6'h02
        |=> cfg_rdata == {16'h0600, 8'h00, REVISION})
        else $error("revision or class bytes wrong");
    a_hdr_zero: assert property (
        cfg_rd && cfg_dw_addr == 6'h03 |=> cfg_rdata == 32'h0)
        else $error("latency or header byte not zero");
    a_rma_set: assert property (ma_kept |=> cfg_rdata[29])
        else $error("master abort flag not set");
    a_rma_clear: assert property (ma_cleared |=> !cfg_rdata[29])
        else $error("master abort flag not cleared");
    a_serr_cause: assert property (
        serr_msg_send |-> $past(dev0_error_event))
        else $error("error message without error event");
    a_enable_or: assert property (
        dev1_system_error_enable |-> hub_serr_msg_enable)
        else $error("message enable ignores device one");
endmodule

bind hbchs_cfg_header hbchs_checker #(.REVISION(REVISION)) i_hbchs_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .hub_master_abort_cpl(hub_master_abort_cpl),
    .dev0_error_event(dev0_error_event),
    .dev1_system_error_enable(dev1_system_error_enable),
    .serr_msg_send(serr_msg_send), .hub_serr_msg_enable(hub_serr_msg_enable)
);

// ### bench/hbchs_hub_model.sv
`timescale 1ns/1ps
// ****
// Hub request logic: completions and error events
// ****
module hbchs_hub_model (
    input logic clk_sys,
    input logic go,
    input logic [1:0] kind,
    output logic master_abort = 1'b0,
    output logic target_abort = 1'b0,
    output logic error_event = 1'b0
);
    // One request yields a single-cycle pulse, never a level
    always @(posedge clk_sys) begin
        master_abort <= go && kind == 2'h0;
        target_abort <= go && kind == 2'h1;
        error_event <= go && kind == 2'h2;
    end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
// ****
// Status header bench
// ****
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_rd = 1'b0;
    logic cfg_wr = 1'b0;
    logic [5:0] cfg_dw_addr = 6'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic dev1_en = 1'b0;
    logic hub_go = 1'b0;
    logic [1:0] hub_kind = 2'h0;
    wire [31:0] cfg_rdata;
    wire cfg_rvalid, ma_cpl, ta_cpl, err_ev, serr_msg_send, hub_en;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int serr_seen = 0;
    hbchs_cfg_header #(.REVISION(8'h5a), .CAP_POINTER(8'h3c)) i_hbchs_cfg_header (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .hub_master_abort_cpl(ma_cpl), .hub_target_abort_cpl(ta_cpl),
        .dev0_error_event(err_ev), .dev1_system_error_enable(dev1_en),
        .serr_msg_send(serr_msg_send), .hub_serr_msg_enable(hub_en)
    );
    hbchs_hub_model i_hbchs_hub_model (
        .clk_sys(clk_sys), .go(hub_go), .kind(hub_kind),
        .master_abort(ma_cpl), .target_abort(ta_cpl), .error_event(err_ev)
    );
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (serr_msg_send === 1'b1) serr_seen <= serr_seen + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            complete_run();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task cfg_write(input logic [5:0] a, input logic [3:0] be,
                   input logic [31:0] d);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_dw_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask
    // Answer lands on the taking edge, so look one step after it
    task cfg_read(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        cfg_rd <= 1'b1;
        cfg_dw_addr <= a;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1;
        check({31'h0, cfg_rvalid}, 32'h1);
        check(cfg_rdata, exp);
    endtask
    task hub_event(input logic [1:0] k);
        @(posedge clk_sys);
        hub_go <= 1'b1;
        hub_kind <= k;
        @(posedge clk_sys);
        hub_go <= 1'b0;
        // Model pulse, design register and message count each add an edge
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        cfg_read(6'h01, 32'h0090_0006);
        check({31'h0, hub_en}, 32'h0);
        cfg_read(6'h02, 32'h0600_005a);
        cfg_read(6'h03, 32'h0);
        cfg_read(6'h0d, 32'h0000_003c);
        cfg_read(6'h00, 32'h0);
        cfg_write(6'h01, 4'hf, 32'hffff_ffff);
        cfg_write(6'h02, 4'hf, 32'hffff_ffff);
        cfg_write(6'h03, 4'hf, 32'hffff_ffff);
        cfg_read(6'h01, 32'h0090_0106);
        cfg_read(6'h02, 32'h0600_005a);
        cfg_read(6'h03, 32'h0);
        hub_event(2'h2);
        check(32'(serr_seen), 32'h1);
        cfg_write(6'h01, 4'h8, 32'h0);
        cfg_read(6'h01, 32'h4090_0106);
        cfg_write(6'h01, 4'h8, 32'h4000_0000);
        cfg_read(6'h01, 32'h0090_0106);
        hub_event(2'h0);
        hub_event(2'h1);
        cfg_read(6'h01, 32'h3090_0106);
        cfg_write(6'h01, 4'h8, 32'h2000_0000);
        cfg_read(6'h01, 32'h1090_0106);
        cfg_write(6'h01, 4'h8, 32'h1000_0000);
        cfg_read(6'h01, 32'h0090_0106);
        check({31'h0, hub_en}, 32'h1);
        cfg_write(6'h01, 4'h2, 32'h0);
        dev1_en <= 1'b1;
        hub_event(2'h2);
        check(32'(serr_seen), 32'h1);
        cfg_read(6'h01, 32'h0090_0006);
        check({31'h0, hub_en}, 32'h1);
        complete_run();
    end
endmodule
